// ==== rtl/conv_ctrl_pkg.sv ====
// constants and types of the converter control register bank
package conv_ctrl_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_TAKEOVER = 8'h05;
    localparam logic [7:0] ADDR_CORE = 8'h06;
    localparam logic [7:0] ADDR_SLEW = 8'h07;
    localparam logic [7:0] ADDR_REGV = 8'h08;

    // serial target address, value arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h48;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int GO_BIT = 7;
    localparam int ADJ_BIT = 6;
    localparam int RIPPLE_BIT = 3;
    localparam int SECOND_REG_LSB = 4;
    localparam int FIRST_REG_LSB = 0;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET = 8'hB1;
    localparam logic [7:0] TAKEOVER_RESET = 8'h40;
    localparam logic [2:0] SLEW_RESET = 3'h6;
    localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;
    localparam logic [4:0] CORE_DEF_LOW = 5'h14;
    localparam logic [4:0] CORE_DEF_HIGH = 5'h1E;
    // regulator defaults indexed by {strap_b, strap_a}
    localparam logic [3:0][7:0] REGV_DEFAULTS = {
        8'h77, 8'h66, 8'h44, 8'h11
    };

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int STEP_UV = 25000;
    localparam int BASE_RATE_UV_PER_US = 225;
    localparam int CLK_MHZ = 250;
    localparam logic [14:0] SLEW_STEP_CYCLES = 15'(
        (STEP_UV * CLK_MHZ + BASE_RATE_UV_PER_US - 1) / BASE_RATE_UV_PER_US);

    // ----------------------------------------
    // serial target states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_ACK, ST_MACK
    } serial_state_type;

endpackage

// ==== rtl/serial_reg_target.sv ====
// two-wire serial target giving register reads and writes
`timescale 1ns/100ps
module serial_reg_target
    import conv_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_oe,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);

    // ----------------------------------------
    // pin filters
    // ----------------------------------------
    logic [1:0] raw;
    logic [1:0] filt;
    assign raw = {scl_pin, sda_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            logic s1;
            logic s2;
            logic s3;
            logic f;
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                    f <= 1'b1;
                end else if (ce) begin
                    s1 <= raw[g];
                    s2 <= s1;
                    s3 <= s2;
                    f <= (s2 == s3) ? s3 : f;
                end
            end
            assign filt[g] = f;
        end
    endgenerate

    // ----------------------------------------
    // bus events
    // ----------------------------------------
    logic scl_q;
    logic sda_q;
    serial_state_type state;
    serial_state_type after_ack;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [3:0] bit_cnt;

    wire scl = filt[1];
    wire sda = filt[0];
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start = scl & scl_q & sda_q & ~sda;
    wire stop = scl & scl_q & ~sda_q & sda;
    wire byte_in = scl_fall && (bit_cnt == 4'h8);
    wire addr_hit = shreg[7:1] == DEV_ADDR;
    wire load_rd = scl_fall && ((state == ST_ACK && after_ack == ST_RDATA)
        || state == ST_MACK);

    assign rd_addr = ptr;

    // ----------------------------------------
    // transfer engine
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state <= ST_IDLE;
            after_ack <= ST_IDLE;
            shreg <= 8'h00;
            ptr <= 8'h00;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else if (ce) begin
            scl_q <= scl;
            sda_q <= sda;
            wr_stb <= 1'b0;
            if (start) begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (load_rd) begin
                state <= ST_RDATA;
                shreg <= {rd_data[6:0], 1'b0};
                sda_oe <= ~rd_data[7];
                bit_cnt <= 4'h1;
                ptr <= ptr + 8'h01;
            end else begin
                case (state)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_in) begin
                            bit_cnt <= 4'h0;
                            state <= ST_ACK;
                            sda_oe <= 1'b1;
                            if (state == ST_ADDR) begin
                                after_ack <= shreg[0] ? ST_RDATA : ST_PTR;
                                if (!addr_hit) begin
                                    state <= ST_IDLE;
                                    sda_oe <= 1'b0;
                                end
                            end else if (state == ST_PTR) begin
                                ptr <= shreg;
                                after_ack <= ST_WDATA;
                            end else begin
                                wr_stb <= 1'b1;
                                wr_addr <= ptr;
                                wr_data <= shreg;
                                ptr <= ptr + 8'h01;
                                after_ack <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state <= after_ack;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                sda_oe <= 1'b0;
                                state <= ST_MACK;
                            end else begin
                                sda_oe <= ~shreg[7];
                                shreg <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise && sda) begin
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ==== rtl/conv_ctrl_regs.sv ====
// converter control register bank behind the serial interface
`timescale 1ns/100ps
module conv_ctrl_regs
    import conv_ctrl_pkg::*;
#(
    parameter logic [14:0] STEP_CYCLES = SLEW_STEP_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic UNDERVOLTAGE_LOCKOUT,
    input wire logic WARM_RESET_PIN_N,
    input wire logic POWER_ON_RESET_OUTPUT,
    input wire logic BACKUP_SUPPLY_LOW,
    input wire logic CORE_DEFAULT_STRAP_PIN,
    input wire logic REG_DEFAULT_STRAP_A,
    input wire logic REG_DEFAULT_STRAP_B,
    input wire logic [2:0] CONVERTER_ENABLED,
    output logic [2:0] FORCED_FIXED_FREQ_BIT,
    output logic LOW_RIPPLE,
    output logic [1:0] SYSTEM_PHASE,
    output logic [1:0] MEMORY_PHASE,
    output logic [2:0] DISCHARGE_ACTIVE,
    output logic CORE_FROM_PIN,
    output logic [4:0] CORE_CODE,
    output logic TRANSITION_BUSY,
    output logic [2:0] FIRST_REG_CODE,
    output logic [2:0] SECOND_REG_CODE
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin;
    assign pin_raw = {REG_DEFAULT_STRAP_B, REG_DEFAULT_STRAP_A,
        CORE_DEFAULT_STRAP_PIN, BACKUP_SUPPLY_LOW, POWER_ON_RESET_OUTPUT,
        WARM_RESET_PIN_N, UNDERVOLTAGE_LOCKOUT};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic f;
            always_ff @(posedge CLK_SYS) begin
                if (RST) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    f <= 1'b0;
                end else if (CE) begin
                    s1 <= pin_raw[g];
                    s2 <= s1;
                    s3 <= s2;
                    f <= (s2 == s3) ? s3 : f;
                end
            end
            assign pin[g] = f;
        end
    endgenerate

    // ----------------------------------------
    // register access port
    // ----------------------------------------
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    serial_reg_target u_target (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .scl_pin(SCL_IN),
        .sda_pin(SDA_IN),
        .sda_oe(SDA_OE),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    assign SDA_OUT = 1'b0;

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [7:0] converter_mode_reg;
    logic go;
    logic core_adj;
    logic [2:0] discharge_sel;
    logic [4:0] core_voltage_code_reg;
    logic [2:0] core_slew_reg;
    logic [2:0] first_reg_code;
    logic [2:0] second_reg_code;
    logic [4:0] cur_code;
    logic [14:0] step_cnt;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire undervoltage_lockout = pin[0];
    wire core_evt = pin[0] | ~pin[1] | pin[2] | pin[3];
    wire [4:0] core_def = pin[4] ? CORE_DEF_HIGH : CORE_DEF_LOW;
    wire [7:0] regv_def = REGV_DEFAULTS[{pin[6], pin[5]}];
    wire wr_mode = wr_stb && (wr_addr == ADDR_MODE);
    wire wr_take = wr_stb && (wr_addr == ADDR_TAKEOVER);
    wire wr_core = wr_stb && (wr_addr == ADDR_CORE);
    wire wr_slew = wr_stb && (wr_addr == ADDR_SLEW);
    wire wr_regv = wr_stb && (wr_addr == ADDR_REGV);
    wire launch = wr_take && wr_data[GO_BIT];
    wire at_target = cur_code == core_voltage_code_reg;
    wire immediate = core_slew_reg == SLEW_IMMEDIATE;
    wire [14:0] interval = STEP_CYCLES >> core_slew_reg;
    wire step_due = step_cnt >= (interval - 15'd1);
    wire [7:0] take_rd = {go, core_adj, 3'b000, discharge_sel};
    wire [7:0] core_rd = {3'b000, core_voltage_code_reg};
    wire [7:0] slew_rd = {5'b00000, core_slew_reg};
    wire [7:0] regv_rd = {1'b0, second_reg_code, 1'b0, first_reg_code};

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    assign rd_data = (rd_addr == ADDR_MODE) ? converter_mode_reg :
        (rd_addr == ADDR_TAKEOVER) ? take_rd :
        (rd_addr == ADDR_CORE) ? core_rd :
        (rd_addr == ADDR_SLEW) ? slew_rd :
        (rd_addr == ADDR_REGV) ? regv_rd : 8'h00;

    // ----------------------------------------
    // mode and discharge controls
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            converter_mode_reg <= MODE_RESET;
            discharge_sel <= TAKEOVER_RESET[2:0];
        end else if (CE) begin
            if (undervoltage_lockout) begin
                converter_mode_reg <= MODE_RESET;
                discharge_sel <= TAKEOVER_RESET[2:0];
            end else begin
                if (wr_mode) begin
                    converter_mode_reg <= wr_data;
                end
                if (wr_take) begin
                    discharge_sel <= wr_data[2:0];
                end
            end
        end
    end

    // ----------------------------------------
    // core select, code, slew, regulators
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            core_adj <= TAKEOVER_RESET[ADJ_BIT];
            core_voltage_code_reg <= CORE_DEF_LOW;
            core_slew_reg <= SLEW_RESET;
            first_reg_code <= REGV_DEFAULTS[0][2:0];
            second_reg_code <= REGV_DEFAULTS[0][6:4];
        end else if (CE) begin
            if (core_evt) begin
                core_adj <= TAKEOVER_RESET[ADJ_BIT];
                core_voltage_code_reg <= core_def;
            end else begin
                if (wr_take) begin
                    core_adj <= wr_data[ADJ_BIT];
                end
                if (wr_core) begin
                    core_voltage_code_reg <= wr_data[4:0];
                end
            end
            if (undervoltage_lockout) begin
                core_slew_reg <= SLEW_RESET;
                first_reg_code <= regv_def[2:0];
                second_reg_code <= regv_def[6:4];
            end else begin
                if (wr_slew) begin
                    core_slew_reg <= wr_data[2:0];
                end
                if (wr_regv) begin
                    // reserved bits 7 and 3 are not stored
                    first_reg_code <= wr_data[FIRST_REG_LSB +: 3];
                    second_reg_code <= wr_data[SECOND_REG_LSB +: 3];
                end
            end
        end
    end

    // ----------------------------------------
    // launch bit
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            go <= TAKEOVER_RESET[GO_BIT];
        end else if (CE) begin
            if (undervoltage_lockout) begin
                go <= 1'b0;
            end else if (launch) begin
                go <= 1'b1;
            end else if (go && at_target) begin
                go <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // voltage transition engine
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cur_code <= CORE_DEF_LOW;
            step_cnt <= 15'd0;
        end else if (CE) begin
            if (core_evt) begin
                cur_code <= core_def;
                step_cnt <= 15'd0;
            end else if (go && !at_target) begin
                if (immediate) begin
                    cur_code <= core_voltage_code_reg;
                    step_cnt <= 15'd0;
                end else if (step_due) begin
                    step_cnt <= 15'd0;
                    if (cur_code < core_voltage_code_reg) begin
                        cur_code <= cur_code + 5'd1;
                    end else begin
                        cur_code <= cur_code - 5'd1;
                    end
                end else begin
                    step_cnt <= step_cnt + 15'd1;
                end
            end else begin
                step_cnt <= 15'd0;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            FORCED_FIXED_FREQ_BIT <= MODE_RESET[2:0];
            LOW_RIPPLE <= MODE_RESET[RIPPLE_BIT];
            SYSTEM_PHASE <= MODE_RESET[7:6];
            MEMORY_PHASE <= MODE_RESET[5:4];
            DISCHARGE_ACTIVE <= 3'b000;
            CORE_FROM_PIN <= TAKEOVER_RESET[ADJ_BIT];
            CORE_CODE <= CORE_DEF_LOW;
            TRANSITION_BUSY <= 1'b0;
            FIRST_REG_CODE <= REGV_DEFAULTS[0][2:0];
            SECOND_REG_CODE <= REGV_DEFAULTS[0][6:4];
        end else if (CE) begin
            FORCED_FIXED_FREQ_BIT <= converter_mode_reg[2:0];
            LOW_RIPPLE <= converter_mode_reg[RIPPLE_BIT];
            SYSTEM_PHASE <= converter_mode_reg[7:6];
            MEMORY_PHASE <= converter_mode_reg[5:4];
            DISCHARGE_ACTIVE <= discharge_sel & ~CONVERTER_ENABLED;
            CORE_FROM_PIN <= core_adj;
            CORE_CODE <= cur_code;
            TRANSITION_BUSY <= go;
            FIRST_REG_CODE <= first_reg_code;
            SECOND_REG_CODE <= second_reg_code;
        end
    end

endmodule

// ==== testbench/conv_ctrl_monitor.sv ====
// assertion checker for the converter control register bank
`timescale 1ns/100ps
module conv_ctrl_monitor
    import conv_ctrl_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic UNDERVOLTAGE_LOCKOUT,
    input wire logic WARM_RESET_PIN_N,
    input wire logic POWER_ON_RESET_OUTPUT,
    input wire logic BACKUP_SUPPLY_LOW,
    input wire logic CORE_DEFAULT_STRAP_PIN,
    input wire logic REG_DEFAULT_STRAP_A,
    input wire logic REG_DEFAULT_STRAP_B,
    input wire logic [2:0] CONVERTER_ENABLED,
    input wire logic [2:0] FORCED_FIXED_FREQ_BIT,
    input wire logic LOW_RIPPLE,
    input wire logic [1:0] SYSTEM_PHASE,
    input wire logic [1:0] MEMORY_PHASE,
    input wire logic [2:0] DISCHARGE_ACTIVE,
    input wire logic CORE_FROM_PIN,
    input wire logic [4:0] CORE_CODE,
    input wire logic TRANSITION_BUSY,
    input wire logic [2:0] FIRST_REG_CODE,
    input wire logic [2:0] SECOND_REG_CODE
);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    wire core_evt = UNDERVOLTAGE_LOCKOUT | ~WARM_RESET_PIN_N |
        POWER_ON_RESET_OUTPUT | BACKUP_SUPPLY_LOW;
    wire [7:0] regv_def =
        REGV_DEFAULTS[{REG_DEFAULT_STRAP_B, REG_DEFAULT_STRAP_A}];
    wire [4:0] core_def =
        CORE_DEFAULT_STRAP_PIN ? CORE_DEF_HIGH : CORE_DEF_LOW;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_mode_rst;
        $fell(RST) |-> FORCED_FIXED_FREQ_BIT == MODE_RESET[2:0] &&
            LOW_RIPPLE == MODE_RESET[3] && SYSTEM_PHASE == MODE_RESET[7:6];
    endproperty
    a_mode_rst: assert property (p_mode_rst)
        else $error("mode reset");
    property p_take_rst;
        $fell(RST) |-> CORE_FROM_PIN && !TRANSITION_BUSY &&
            CORE_CODE == CORE_DEF_LOW;
    endproperty
    a_take_rst: assert property (p_take_rst)
        else $error("takeover reset");
    property p_regv_rst;
        $fell(RST) |-> FIRST_REG_CODE == REGV_DEFAULTS[0][2:0] &&
            SECOND_REG_CODE == REGV_DEFAULTS[0][6:4];
    endproperty
    a_regv_rst: assert property (p_regv_rst)
        else $error("regulator reset");
    property p_dis_off;
        CE && CONVERTER_ENABLED == 3'h7 |=> DISCHARGE_ACTIVE == 3'h0;
    endproperty
    a_dis_off: assert property (p_dis_off)
        else $error("discharge on");
    property p_done_stable;
        disable iff (RST || UNDERVOLTAGE_LOCKOUT)
        $fell(TRANSITION_BUSY) |-> $stable(CORE_CODE);
    endproperty
    a_done_stable: assert property (p_done_stable)
        else $error("code moved at done");
    property p_lock_go;
        (UNDERVOLTAGE_LOCKOUT && CE) [*8] |-> !TRANSITION_BUSY;
    endproperty
    a_lock_go: assert property (p_lock_go)
        else $error("lockout launch");
    property p_lock_defs;
        (UNDERVOLTAGE_LOCKOUT && CE) [*8] |->
            FORCED_FIXED_FREQ_BIT == MODE_RESET[2:0] &&
            MEMORY_PHASE == MODE_RESET[5:4] &&
            {SECOND_REG_CODE, FIRST_REG_CODE} ==
            {regv_def[6:4], regv_def[2:0]};
    endproperty
    a_lock_defs: assert property (p_lock_defs)
        else $error("lockout defaults");
    property p_core_evt;
        (core_evt && CE) [*8] |-> CORE_FROM_PIN && CORE_CODE == core_def;
    endproperty
    a_core_evt: assert property (p_core_evt)
        else $error("core defaults");
endmodule

bind conv_ctrl_regs conv_ctrl_monitor conv_ctrl_monitor_i (.*);

// ==== testbench/serial_host.sv ====
// two-wire serial host model driving the register bank
`timescale 1ns/100ps
module serial_host
    import conv_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task bit_io(input logic b, output logic r);
        tick(2);
        sda = b;
        tick(9);
        scl = 1'b1;
        tick(9);
        r = sda_line;
        scl = 1'b0;
    endtask
    task frame(input logic a);
        tick(2);
        sda = a;
        tick(9);
        scl = 1'b1;
        tick(9);
        sda = ~a;
        tick(9);
    endtask
    task start();
        frame(1'b1);
        scl = 1'b0;
    endtask
    task stop();
        frame(1'b0);
    endtask
    task xfer(input logic [7:0] tx, input logic last,
        output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(last, r);
        ack = ~r;
    endtask
    task write_reg(input logic [7:0] a, input logic [7:0] d,
        output logic ack);
        logic [7:0] x;
        logic k1, k2, k3;
        if (a == ADDR_REGV)
            d = d & 8'h77;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, x, k1);
        xfer(a, 1'b1, x, k2);
        xfer(d, 1'b1, x, k3);
        stop();
        ack = k1 & k2 & k3;
    endtask
    task read_reg(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] x;
        logic k;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, x, k);
        xfer(a, 1'b1, x, k);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, x, k);
        xfer(8'hFF, 1'b1, d, k);
        stop();
    endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the converter control register bank
`timescale 1ns/100ps
`define CMP(e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("FAIL t=%0t got %h exp %h", $time, g, e); \
    end \
end
module testbench
    import conv_ctrl_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic undervoltage_lockout = 1'b0, warm_n = 1'b1, por = 1'b0, bkup = 1'b0, ce = 1'b1;
    logic strap_c = 1'b0, strap_a = 1'b1, strap_b = 1'b0;
    logic [2:0] conv_en = 3'h7;
    logic scl, sda, sda_oe, sda_line, ripple, from_pin, busy;
    logic [2:0] fffb, dis, reg1, reg2;
    logic [1:0] sys_ph, mem_ph;
    logic [4:0] code;
    logic [7:0] expq[$];
    logic [7:0] res = 8'h00, exp_v;
    logic res_v = 1'b0;
    int error_cnt = 0, cmp_count = 0, cyc = 0, blen = 0, last_len = 0;
    int seed = 32'hFB02482C;
    assign sda_line = sda & ~sda_oe;

    conv_ctrl_regs #(.STEP_CYCLES(15'd64)) conv_ctrl_regs_i (
        .CLK_SYS(clk_sys), .RST(rst), .CE(ce), .SCL_IN(scl),
        .SDA_IN(sda_line), .SDA_OUT(), .SDA_OE(sda_oe),
        .UNDERVOLTAGE_LOCKOUT(undervoltage_lockout), .WARM_RESET_PIN_N(warm_n),
        .POWER_ON_RESET_OUTPUT(por), .BACKUP_SUPPLY_LOW(bkup),
        .CORE_DEFAULT_STRAP_PIN(strap_c), .REG_DEFAULT_STRAP_A(strap_a),
        .REG_DEFAULT_STRAP_B(strap_b), .CONVERTER_ENABLED(conv_en),
        .FORCED_FIXED_FREQ_BIT(fffb), .LOW_RIPPLE(ripple),
        .SYSTEM_PHASE(sys_ph), .MEMORY_PHASE(mem_ph),
        .DISCHARGE_ACTIVE(dis), .CORE_FROM_PIN(from_pin), .CORE_CODE(code),
        .TRANSITION_BUSY(busy), .FIRST_REG_CODE(reg1),
        .SECOND_REG_CODE(reg2));
    serial_host serial_host_i (.clk(clk_sys), .sda_line(sda_line),
        .scl(scl), .sda(sda));

    // ----------------------------------------
    // clock, watchdog, result checking
    // ----------------------------------------
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        blen <= busy ? blen + 1 : 0;
        if (!busy && blen != 0)
            last_len <= blen;
        if (cyc == 60000) begin
            error_cnt++;
            close_out();
        end
        if (res_v) begin
            exp_v = expq.pop_front();
            `CMP(exp_v, res)
        end
    end

    task close_out();
        $display("errors %0d checks %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task tk(input int n);
        serial_host_i.tick(n);
    endtask
    task check(input logic [7:0] e, input logic [7:0] g);
        expq.push_back(e);
        res = g;
        res_v = 1'b1;
        tk(1);
        res_v = 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        serial_host_i.write_reg(a, d, k);
        check(8'h01, 8'(k));
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        serial_host_i.read_reg(a, d);
        check(e, d);
    endtask
    task go(input logic [7:0] t, input logic [7:0] s);
        wr(ADDR_CORE, t);
        wr(ADDR_SLEW, s);
        wr(ADDR_TAKEOVER, 8'h80);
        for (int i = 0; i < 4000 && busy !== 1'b0; i++)
            tk(1);
        tk(4);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        int d6;
        logic [7:0] v;
        logic k;
        tk(2);
        rst = 1'b0;
        tk(10);
        rd(ADDR_MODE, MODE_RESET);
        rd(ADDR_TAKEOVER, TAKEOVER_RESET);
        rd(ADDR_CORE, 8'(CORE_DEF_LOW));
        rd(ADDR_SLEW, 8'(SLEW_RESET));
        rd(ADDR_REGV, REGV_DEFAULTS[0]);
        rd(8'h09, 8'h00);
        serial_host_i.start();
        serial_host_i.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, v, k);
        serial_host_i.stop();
        check(8'h00, 8'(k));
        for (int i = 0; i < 4; i++) begin
            v = {4'($random(seed)), 4'(i * 5)};
            wr(ADDR_MODE, v);
            check(v, {sys_ph, mem_ph, ripple, fffb});
        end
        wr(ADDR_TAKEOVER, 8'h7F);
        rd(ADDR_TAKEOVER, 8'h47);
        check(8'h01, 8'(from_pin));
        for (int i = 0; i < 4; i++) begin
            conv_en = 3'($random(seed));
            tk(3);
            check({5'h0, ~conv_en}, 8'(dis));
        end
        v = 8'(dis);
        ce = 1'b0;
        conv_en = ~conv_en;
        tk(3);
        check(v, 8'(dis));
        ce = 1'b1;
        wr(ADDR_TAKEOVER, 8'h00);
        check(8'h00, {4'h0, from_pin, dis});
        wr(ADDR_CORE, 8'hFF);
        rd(ADDR_CORE, 8'h1F);
        check(8'(CORE_DEF_LOW), 8'(code));
        go(8'h1F, 8'h06);
        d6 = last_len;
        check(8'h1F, 8'(code));
        go(8'h14, 8'h06);
        go(8'h1F, 8'h04);
        check(8'd33, 8'(last_len - d6));
        rd(ADDR_TAKEOVER, 8'h00);
        go(8'h00, 8'h07);
        check(8'd10, 8'(d6 - last_len));
        check(8'h00, 8'(code));
        wr(ADDR_REGV, 8'hFF);
        rd(ADDR_REGV, 8'h77);
        wr(ADDR_MODE, 8'h5A);
        wr(ADDR_CORE, 8'h1F);
        wr(ADDR_SLEW, 8'h00);
        wr(ADDR_TAKEOVER, 8'h80);
        {strap_c, strap_b, strap_a} = {1'b1, 2'($random(seed))};
        tk(20);
        check(8'h01, 8'(busy));
        undervoltage_lockout = 1'b1;
        tk(20);
        check(8'h1E, {2'h0, busy, code});
        check(REGV_DEFAULTS[{strap_b, strap_a}], {1'b0, reg2, 1'b0, reg1});
        check(MODE_RESET, {sys_ph, mem_ph, ripple, fffb});
        undervoltage_lockout = 1'b0;
        tk(10);
        rd(ADDR_TAKEOVER, TAKEOVER_RESET);
        rd(ADDR_SLEW, 8'(SLEW_RESET));
        wr(ADDR_MODE, 8'h5A);
        for (int e = 0; e < 3; e++) begin
            wr(ADDR_CORE, 8'h03);
            wr(ADDR_TAKEOVER, 8'h00);
            warm_n = 1'(e != 0);
            por = 1'(e == 1);
            bkup = 1'(e == 2);
            tk(20);
            check(8'h01, 8'(from_pin));
            {warm_n, por, bkup} = 3'h4;
            tk(10);
            rd(ADDR_CORE, 8'h1E);
            rd(ADDR_MODE, 8'h5A);
        end
        close_out();
    end
endmodule
